// ==== core/ccrp_cfg.svh ====
`ifndef CCRP_CFG_SVH
`define CCRP_CFG_SVH
// register byte addresses
`define CCRP_A_SEL          12'h000
`define CCRP_A_REC0_CTL     12'h004
`define CCRP_A_REC1_CTL     12'h008
`define CCRP_A_PWR_AFG      12'h00C
`define CCRP_A_PWR_CNV      12'h010
`define CCRP_A_FMT0         12'h014
`define CCRP_A_FMT1         12'h018
`define CCRP_A_BIND0        12'h01C
`define CCRP_A_BIND1        12'h020
`define CCRP_A_STATUS       12'h024
`define CCRP_A_GATES        12'h028
// power state codes
`define CCRP_D0             2'h0
`define CCRP_D1             2'h1
`define CCRP_D2             2'h2
`define CCRP_D3             2'h3
// reset values
`define CCRP_FMT_RST        16'h0011
`define CCRP_BIND_RST       8'h00
// format fields
`define CCRP_F_TYPE         15
`define CCRP_F_RATE         14
`define CCRP_F_MULT_HI      13
`define CCRP_F_MULT_LO      11
`define CCRP_F_DIV_HI       10
`define CCRP_F_DIV_LO       8
`define CCRP_F_WID_HI       6
`define CCRP_F_WID_LO       4
`define CCRP_F_CH_HI        3
`define CCRP_F_CH_LO        0
`define CCRP_MULT_X1        3'h0
`define CCRP_MULT_X2        3'h1
`define CCRP_MULT_X4        3'h3
`define CCRP_WID_16         3'h1
`define CCRP_WID_24         3'h3
`define CCRP_CH_ONE_STREAM  4'h1
`define CCRP_CH_TWO_STREAM  4'h3
`define CCRP_SLOT_LOW       4'h0
`define CCRP_SLOT_HIGH      4'h2
`define CCRP_GAIN_MAX       4'hF
// resume time: 10 ms at 50 ns per cycle
`define CCRP_RESUME_NS      10000000
`define CCRP_CLK_NS         50
`define CCRP_BCLK_TIMEOUT   8'hFF
`endif

// ==== core/ccrp_pkg.sv ====
package ccrp_pkg;
    typedef enum logic [1:0] {
        CCRP_PD0, CCRP_PD1, CCRP_PD2, CCRP_PD3
    } ccrp_pwr_t;

    typedef enum logic {CCRP_RES_IDLE, CCRP_RES_WAIT} ccrp_res_t;

    typedef struct packed {
        logic dig_io;       // spdif io, digital_microphone_input, dacs, adcs, rec gain, clocks
        logic analog_mix;   // boost, mixer, mixer volumes, analog beep, bias
        logic port_func;    // port functions, loop-through
        logic port_amp;     // port amps and references at full drive
        logic amp_low;      // port amps and references in low drive
        logic always_on;    // gpio and digital beep
    } ccrp_gate_t;

    typedef struct packed {
        logic       psel;
        logic       penable;
        logic       pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } ccrp_apb_req_t;
endpackage : ccrp_pkg

// ==== core/ccrp_top.sv ====
`include "ccrp_cfg.svh"
// Operation
// [RL1] four port selectors, two-bit source choice each, fixed source sets
// [RL2] two record selectors of twelve sources, gain 0..22.5 dB in 1.5 dB
// [RL3] group, each converter and pin-47 node hold settable power states
// [RL4] converters run only while in D0
// [RL5] per-function gating by group power state per function table
// [RL6] in D0 a function runs only if its node state is also D0; only record converters 0,1 check it, nodes 2..5 gate nothing
// [RL7] D1 disables converters, keeps mixing, loop-through and ports
// [RL8] D2 also disables mixer and ports, amps and references stay on
// [RL9] D3 shuts converters, amps and references go to low drive
// [RL10] D3 to D0 resume completes within 10 ms
// [RL11] group power state resets to D3
// [RL12] jack sensing and link only while the bit clock runs
// [RL13] software enters D3 and powers down ports before reference off
// [RL14] converters use distinct nonzero streams or share one stream
// [RL15] digital audio input never joins a record converter stream
// [RL16] shared stream requires equal sample rate and width
// [RL17] lowest channel slot accepts only even values
// [RL18] shared stream only if critical entries match and channels add up
// [RL19] software sets equal streams, slots 0 and 2, channel field 0011
// [RL20] format bit 15 zero for pcm, non-pcm unsupported
// [RL21] format bit 14 selects 48 kHz or 44.1 kHz base
// [RL22] bits 13:11 allow x1, x2, x4 only
// [RL23] width codes 16, 20, 24 bits only; divisor must be one
// [RL24] channel field is count minus one, single channel unsupported
// [RL25] binding holds stream in 7:4 and lowest slot 0 or 2 in 3:0
module ccrp_top (
    input  wire logic                 pclk,          // 20 MHz bus clock
    input  wire logic                 presetn,       // async reset, low
    input  wire ccrp_pkg::ccrp_apb_req_t apb_req,    // apb request group
    output logic                      pready,        // apb ready
    output logic [31:0]               prdata,        // apb read data
    output logic                      pslverr,       // apb error
    input  wire logic                 bit_clk,       // link bit clock
    output ccrp_pkg::ccrp_gate_t      gate,          // power enables
    output logic [7:0]                port_sel,      // four 2-bit selects
    output logic [7:0]                rec_sel,       // two 4-bit selects
    output logic [7:0]                rec_gain,      // two 4-bit gains
    output logic [1:0]                cnv_run,       // record converters on
    output logic [1:0]                stream_valid,  // capture stream made
    output logic                      shared_stream, // four-channel stream
    output logic                      sense_en,      // jack sensing on
    output logic                      link_active    // link interface on
);
    import ccrp_pkg::*;

    localparam int unsigned RESUME_CYC = `CCRP_RESUME_NS / `CCRP_CLK_NS;

    logic [7:0]  sel_ff;
    logic [7:0]  rctl_ff [2];
    ccrp_pwr_t   afg_ff;
    logic [1:0]  cpwr_ff [6];   // 0,1 record; 2..4 playback; 5 pin 47 node
    logic [15:0] fmt_ff  [2];
    logic [7:0]  bind_ff [2];
    logic        res_busy_ff;
    logic [18:0] res_cnt_ff;
    logic        bck_s1_ff, bck_s2_ff, bck_s3_ff;
    logic [7:0]  bck_idle_ff;
    logic        bck_run_ff;

    wire wr = apb_req.psel & apb_req.penable & apb_req.pwrite;
    wire [11:0] a = apb_req.paddr;
    wire [31:0] d = apb_req.pwdata;

    // single-cycle access phase: pready is high in every cycle after reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) pready <= 1'b0;
        else          pready <= 1'b1;
    end

    // port selectors, raw two-bit choices
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)                       sel_ff <= 8'h00;
        else if (wr && a == `CCRP_A_SEL)    sel_ff <= d[7:0]; // RL1
    end

    // record selectors: [3:0] source, [7:4] gain in 1.5 dB steps
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_rec
            logic [11:0] ra;
            logic [3:0]  src;
            assign ra  = g ? `CCRP_A_REC1_CTL : `CCRP_A_REC0_CTL;
            // sources 12..15 do not exist; clamp keeps selection legal
            assign src = (d[3:0] > 4'hB) ? 4'hB : d[3:0];
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn)             rctl_ff[g] <= 8'h00;
                else if (wr && a == ra)   rctl_ff[g] <= {d[7:4], src}; // RL2
            end

            logic [11:0] fa;
            logic [11:0] ba;
            assign fa = g ? `CCRP_A_FMT1 : `CCRP_A_FMT0;
            assign ba = g ? `CCRP_A_BIND1 : `CCRP_A_BIND0;
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn)           fmt_ff[g] <= `CCRP_FMT_RST;
                else if (wr && a == fa) fmt_ff[g] <= d[15:0]; // RL20
            end
            // odd slots are refused: the low bit of the slot is forced to 0
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn)           bind_ff[g] <= `CCRP_BIND_RST;
                else if (wr && a == ba) bind_ff[g] <= {d[7:1], 1'b0}; // RL17
            end
        end
    endgenerate

    // group power state, resets to D3
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            afg_ff <= CCRP_PD3; // RL11
        else if (wr && a == `CCRP_A_PWR_AFG)
            afg_ff <= ccrp_pwr_t'(d[1:0]); // RL3
    end

    // node power states, two bits each
    generate
        for (g = 0; g < 6; g++) begin : g_node
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn)
                    cpwr_ff[g] <= `CCRP_D3;
                else if (wr && a == `CCRP_A_PWR_CNV)
                    cpwr_ff[g] <= d[2*g +: 2]; // RL3
            end
        end
    endgenerate

    // resume timer: digital functions wait for references to settle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            res_busy_ff <= 1'b0;
            res_cnt_ff  <= '0;
        end else if (wr && a == `CCRP_A_PWR_AFG && afg_ff == CCRP_PD3
                     && d[1:0] == `CCRP_D0) begin
            res_busy_ff <= 1'b1; // RL10
            res_cnt_ff  <= 19'(RESUME_CYC - 1);
        end else if (res_busy_ff) begin
            if (res_cnt_ff == '0) res_busy_ff <= 1'b0;
            else                  res_cnt_ff  <= res_cnt_ff - 19'd1;
        end
    end

    // bit clock presence; first sync flop feeds only the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bck_s1_ff <= 1'b0;
            bck_s2_ff <= 1'b0;
            bck_s3_ff <= 1'b0;
        end else begin
            bck_s1_ff <= bit_clk;
            bck_s2_ff <= bck_s1_ff;
            bck_s3_ff <= bck_s2_ff;
        end
    end

    // 400 ns bit clock toggles every 4 cycles; 255 without edge is stopped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bck_idle_ff <= `CCRP_BCLK_TIMEOUT;
            bck_run_ff  <= 1'b0;
        end else if (bck_s2_ff != bck_s3_ff) begin
            bck_idle_ff <= 8'h00;
            bck_run_ff  <= 1'b1;
        end else if (bck_idle_ff != `CCRP_BCLK_TIMEOUT) begin
            bck_idle_ff <= bck_idle_ff + 8'd1;
        end else begin
            bck_run_ff  <= 1'b0;
        end
    end

    // function gating
    ccrp_gate_t nxt_gate;
    always_comb begin
        nxt_gate            = '0;
        nxt_gate.always_on  = 1'b1; // RL5
        case (afg_ff)
            CCRP_PD0: begin
                nxt_gate.dig_io     = ~res_busy_ff; // RL5
                nxt_gate.analog_mix = 1'b1;
                nxt_gate.port_func  = 1'b1;
                nxt_gate.port_amp   = 1'b1;
            end
            CCRP_PD1: begin
                nxt_gate.analog_mix = 1'b1; // RL7
                nxt_gate.port_func  = 1'b1;
                nxt_gate.port_amp   = 1'b1;
            end
            CCRP_PD2: begin
                nxt_gate.port_amp   = 1'b1; // RL8
            end
            default: begin
                nxt_gate.amp_low    = 1'b1; // RL9
            end
        endcase
    end

    // format legality per converter
    logic [1:0] fmt_ok;
    logic [1:0] nxt_run;
    logic [1:0] nxt_valid;
    logic       nxt_shared;
    always_comb begin
        logic [2:0] m;
        logic [2:0] w;
        m       = 3'h0;
        w       = 3'h0;
        fmt_ok  = 2'b00;
        nxt_run = 2'b00;
        for (int i = 0; i < 2; i++) begin
            m = fmt_ff[i][`CCRP_F_MULT_HI:`CCRP_F_MULT_LO];
            w = fmt_ff[i][`CCRP_F_WID_HI:`CCRP_F_WID_LO];
            fmt_ok[i] = !fmt_ff[i][`CCRP_F_TYPE] // RL20
                && (m == `CCRP_MULT_X1 || m == `CCRP_MULT_X2
                    || m == `CCRP_MULT_X4) // RL22
                && w >= `CCRP_WID_16 && w <= `CCRP_WID_24 // RL23
                && fmt_ff[i][`CCRP_F_DIV_HI:`CCRP_F_DIV_LO] == 3'h0; // RL23
            nxt_run[i] = nxt_gate.dig_io && afg_ff == CCRP_PD0 // RL4
                && cpwr_ff[i] == `CCRP_D0; // RL6
        end
    end

    // stream assembly; only record converters can share, digital input never
    wire [3:0] s0 = bind_ff[0][7:4];
    wire [3:0] s1 = bind_ff[1][7:4];
    wire same  = s0 == s1 && s0 != 4'h0; // RL14 RL15
    wire match = fmt_ff[0] == fmt_ff[1]; // RL16 RL21
    always_comb begin
        nxt_shared = 1'b0;
        nxt_valid  = 2'b00;
        if (same) begin
            // both critical entries identical, slots 0/2, count field 0011
            nxt_shared = match && &fmt_ok && &nxt_run // RL18
                && fmt_ff[0][`CCRP_F_CH_HI:`CCRP_F_CH_LO]
                   == `CCRP_CH_TWO_STREAM // RL24
                && ((bind_ff[0][3:0] == `CCRP_SLOT_LOW
                     && bind_ff[1][3:0] == `CCRP_SLOT_HIGH)
                    || (bind_ff[0][3:0] == `CCRP_SLOT_HIGH
                     && bind_ff[1][3:0] == `CCRP_SLOT_LOW)); // RL25
            nxt_valid  = {nxt_shared, nxt_shared};
        end else begin
            for (int i = 0; i < 2; i++)
                nxt_valid[i] = bind_ff[i][7:4] != 4'h0 && fmt_ok[i] // RL14
                    && nxt_run[i]
                    && bind_ff[i][3:0] == `CCRP_SLOT_LOW // RL25
                    && fmt_ff[i][`CCRP_F_CH_HI:`CCRP_F_CH_LO]
                       == `CCRP_CH_ONE_STREAM; // RL24
        end
    end
    // digital audio input is outside this selector set; stereo only

    // registered outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gate          <= '0;
            port_sel      <= 8'h00;
            rec_sel       <= 8'h00;
            rec_gain      <= 8'h00;
            cnv_run       <= 2'b00;
            stream_valid  <= 2'b00;
            shared_stream <= 1'b0;
            sense_en      <= 1'b0;
            link_active   <= 1'b0;
        end else begin
            gate          <= nxt_gate;
            port_sel      <= sel_ff; // RL1
            rec_sel       <= {rctl_ff[1][3:0], rctl_ff[0][3:0]}; // RL2
            // record gain only acts while record volume is powered
            rec_gain      <= nxt_gate.dig_io ?
                             {rctl_ff[1][7:4], rctl_ff[0][7:4]} : 8'h00;
            cnv_run       <= nxt_run; // RL4
            stream_valid  <= nxt_valid; // RL18
            shared_stream <= nxt_shared; // RL18
            sense_en      <= bck_run_ff; // RL12
            link_active   <= bck_run_ff; // RL12
        end
    end

    // read mux
    logic [31:0] nxt_rd;
    logic        nxt_err;
    always_comb begin
        nxt_rd  = 32'h0;
        nxt_err = 1'b0;
        if (a == `CCRP_A_SEL)             nxt_rd = {24'h0, sel_ff};
        else if (a == `CCRP_A_REC0_CTL)   nxt_rd = {24'h0, rctl_ff[0]};
        else if (a == `CCRP_A_REC1_CTL)   nxt_rd = {24'h0, rctl_ff[1]};
        else if (a == `CCRP_A_PWR_AFG)    nxt_rd = {30'h0, afg_ff};
        else if (a == `CCRP_A_PWR_CNV)
            nxt_rd = {20'h0, cpwr_ff[5], cpwr_ff[4], cpwr_ff[3],
                      cpwr_ff[2], cpwr_ff[1], cpwr_ff[0]};
        else if (a == `CCRP_A_FMT0)       nxt_rd = {16'h0, fmt_ff[0]};
        else if (a == `CCRP_A_FMT1)       nxt_rd = {16'h0, fmt_ff[1]};
        else if (a == `CCRP_A_BIND0)      nxt_rd = {24'h0, bind_ff[0]};
        else if (a == `CCRP_A_BIND1)      nxt_rd = {24'h0, bind_ff[1]};
        else if (a == `CCRP_A_STATUS)
            nxt_rd = {25'h0, bck_run_ff, res_busy_ff, nxt_shared,
                      nxt_valid, nxt_run};
        else if (a == `CCRP_A_GATES)      nxt_rd = {26'h0, nxt_gate};
        else                              nxt_err = 1'b1;
    end

    // read data registered in the setup cycle, valid in the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0;
            pslverr <= 1'b0;
        end else begin
            prdata  <= nxt_rd;
            pslverr <= nxt_err & apb_req.psel;
        end
    end
endmodule : ccrp_top

// ==== bench/ccrp_link_model.sv ====
module ccrp_link_model (
    run,    // controller keeps the bit clock going
    bit_clk // link bit clock to the codec
);
    timeunit 1ns;
    timeprecision 1ns;
    input  wire logic run;
    output logic      bit_clk;
    initial bit_clk = 1'b0;
    // a stopped clock parks low, as with the controller in D3
    always begin
        #200;
        bit_clk = run ? ~bit_clk : 1'b0;
    end
endmodule : ccrp_link_model

// ==== bench/ccrp_top_assertions.sv ====
module ccrp_top_chk (
    input wire logic                pclk,          // bus clock
    input wire logic                presetn,       // async reset, low
    input wire logic                bit_clk,       // link bit clock
    input wire ccrp_pkg::ccrp_gate_t gate,         // power enables
    input wire logic [7:0]          rec_gain,      // record gains
    input wire logic [1:0]          cnv_run,       // converters on
    input wire logic                shared_stream, // shared stream
    input wire logic                sense_en,      // jack sensing on
    input wire logic                link_active    // link interface on
);
    import ccrp_pkg::*;
    logic [8:0] idle_ff;
    logic       bclk_q_ff;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // counts pclk cycles without a bit clock edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idle_ff   <= 9'h000;
            bclk_q_ff <= 1'b0;
        end else begin
            bclk_q_ff <= bit_clk;
            if (bit_clk != bclk_q_ff) idle_ff <= 9'h000;
            else if (idle_ff != 9'h1FF) idle_ff <= idle_ff + 9'h001;
        end
    end
    sequence s_run_lost;
        cnv_run != 2'h3 ##1 cnv_run != 2'h3;
    endsequence
    AST_SENSE_STOP: assert property (idle_ff >= 9'h130 |-> !sense_en)
        else $error("sensing on with bit clock stopped");
    AST_LINK_SENSE: assert property (sense_en == link_active)
        else $error("link and sensing disagree");
    AST_ALWAYS_ON: assert property ($past(presetn) |-> gate.always_on)
        else $error("always-on group dropped");
    AST_AMP_MODE: assert property (
        $past(presetn) |-> gate.port_amp != gate.amp_low)
        else $error("amps neither full nor low drive");
    AST_MIX_AMP: assert property (
        gate.analog_mix |-> gate.port_amp && gate.port_func)
        else $error("mixer on without ports");
    AST_DIG_MIX: assert property (gate.dig_io |-> gate.analog_mix)
        else $error("digital on without mixer");
    AST_CNV_D0: assert property (
        cnv_run != 2'h0 |-> gate.dig_io)
        else $error("converter runs outside D0");
    AST_GAIN_OFF: assert property (
        !gate.dig_io && !$past(gate.dig_io) |-> rec_gain == 8'h00)
        else $error("record gain active outside D0");
    AST_SHARED_RUN: assert property (s_run_lost |-> !shared_stream)
        else $error("shared stream without both converters");
endmodule : ccrp_top_chk

bind ccrp_top ccrp_top_chk u_chk (
    .pclk(pclk), .presetn(presetn), .bit_clk(bit_clk), .gate(gate),
    .rec_gain(rec_gain), .cnv_run(cnv_run), .shared_stream(shared_stream),
    .sense_en(sense_en), .link_active(link_active)
);

// ==== bench/test_ccrp_top.sv ====
`include "ccrp_cfg.svh"
module test_ccrp_top;
    timeunit 1ns;
    timeprecision 1ns;
    import ccrp_pkg::*;
    logic          pclk = 1'b0;
    logic          presetn = 1'b0;
    logic          run = 1'b0;
    ccrp_apb_req_t req = '0;
    logic          pready, pslverr, bit_clk, shared_stream, sense_en;
    logic          link_active, er;
    logic [31:0]   prdata, rd;
    ccrp_gate_t    gate;
    logic [7:0]    port_sel, rec_sel, rec_gain;
    logic [1:0]    cnv_run, stream_valid;
    int            n_mismatch = 0;
    int            n_compared = 0;
    int            cycles = 0;
    always #25 pclk = ~pclk;
    ccrp_top uut (
        .pclk(pclk), .presetn(presetn), .apb_req(req), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .bit_clk(bit_clk),
        .gate(gate), .port_sel(port_sel), .rec_sel(rec_sel),
        .rec_gain(rec_gain), .cnv_run(cnv_run),
        .stream_valid(stream_valid), .shared_stream(shared_stream),
        .sense_en(sense_en), .link_active(link_active)
    );
    ccrp_link_model u_link (.run(run), .bit_clk(bit_clk));
    task automatic report_and_stop();
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : report_and_stop
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // idle cycle first, so a release never meets a new setup
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] d);
        @(posedge pclk);
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        req.penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask : xfer
    task automatic rd_chk(input string what, input logic [11:0] a,
                          input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        check(what, rd, exp);
    endtask : rd_chk
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            report_and_stop();
        end
    end
    initial begin
        int seq [4] = '{2, 3, 1, 0};
        logic [5:0] gexp [4] = '{6'h3D, 6'h1D, 6'h05, 6'h03};
        logic [15:0] fmt [13] = '{16'h0013, 16'h4013, 16'h0813, 16'h8013,
            16'h1013, 16'h0003, 16'h0113, 16'h0011, 16'h0073, 16'h1813,
            16'h2013, 16'h0023, 16'h0033};
        logic sh [13] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0,
            1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk("afg", `CCRP_A_PWR_AFG, 32'h3);
        rd_chk("nodes", `CCRP_A_PWR_CNV, 32'hFFF);
        rd_chk("fmt", `CCRP_A_FMT0, 32'h0011);
        check("gate", 32'(gate), 32'h03);
        xfer(1'b0, 12'h02C, 32'h0);
        check("slverr", 32'(er), 32'h1);
        check("unmapped", rd, 32'h0);
        xfer(1'b1, `CCRP_A_SEL, 32'hE4);
        xfer(1'b1, `CCRP_A_REC0_CTL, 32'hFC);
        xfer(1'b1, `CCRP_A_REC1_CTL, 32'h35);
        repeat (3) @(posedge pclk);
        check("port_sel", 32'(port_sel), 32'hE4);
        check("rec_sel", 32'(rec_sel), 32'h5B);
        check("gain_off", 32'(rec_gain), 32'h0);
        // D3 left only for D2 or D1, so the long resume wait is never started
        foreach (seq[i]) begin
            xfer(1'b1, `CCRP_A_PWR_AFG, 32'(seq[i]));
            repeat (3) @(posedge pclk);
            check("gate", 32'(gate), 32'(gexp[seq[i]]));
            rd_chk("afg", `CCRP_A_PWR_AFG, 32'(seq[i]));
        end
        check("gain_on", 32'(rec_gain), 32'h3F);
        rd_chk("gates", `CCRP_A_GATES, 32'h3D);
        check("cnv_off", 32'(cnv_run), 32'h0);
        xfer(1'b1, `CCRP_A_PWR_CNV, 32'hFF0);
        repeat (3) @(posedge pclk);
        check("cnv_on", 32'(cnv_run), 32'h3);
        xfer(1'b1, `CCRP_A_BIND0, 32'h13);
        rd_chk("slot", `CCRP_A_BIND0, 32'h12);
        xfer(1'b1, `CCRP_A_BIND0, 32'h10);
        xfer(1'b1, `CCRP_A_BIND1, 32'h20);
        repeat (3) @(posedge pclk);
        check("single", 32'(stream_valid), 32'h3);
        rd_chk("status", `CCRP_A_STATUS, 32'h0F);
        xfer(1'b1, `CCRP_A_BIND1, 32'h00);
        repeat (3) @(posedge pclk);
        check("unused", 32'(stream_valid), 32'h1);
        xfer(1'b1, `CCRP_A_BIND1, 32'h12);
        foreach (fmt[i]) begin
            xfer(1'b1, `CCRP_A_FMT0, 32'(fmt[i]));
            xfer(1'b1, `CCRP_A_FMT1, 32'(fmt[i]));
            repeat (3) @(posedge pclk);
            check("shared", 32'(shared_stream), 32'(sh[i]));
        end
        xfer(1'b1, `CCRP_A_BIND1, 32'h10);
        repeat (3) @(posedge pclk);
        check("slots", 32'(shared_stream), 32'h0);
        xfer(1'b1, `CCRP_A_BIND1, 32'h12);
        xfer(1'b1, `CCRP_A_FMT0, 32'h0013);
        xfer(1'b1, `CCRP_A_FMT1, 32'h4013);
        repeat (3) @(posedge pclk);
        check("rate_mix", 32'(shared_stream), 32'h0);
        xfer(1'b1, `CCRP_A_PWR_AFG, 32'h1);
        repeat (3) @(posedge pclk);
        check("cnv_d1", 32'(cnv_run), 32'h0);
        check("sense0", 32'(sense_en), 32'h0);
        run <= 1'b1;
        repeat (40) @(posedge pclk);
        check("sense1", 32'({sense_en, link_active}), 32'h3);
        xfer(1'b1, `CCRP_A_PWR_AFG, 32'h3);
        xfer(1'b1, `CCRP_A_PWR_CNV, 32'hFFF);
        repeat (3) @(posedge pclk);
        check("gate_d3", 32'(gate), 32'h03);
        check("sense_d3", 32'(sense_en), 32'h1);
        // leaving D3 straight for D0 starts the settle wait
        xfer(1'b1, `CCRP_A_PWR_AFG, 32'h0);
        repeat (3) @(posedge pclk);
        check("resume_gate", 32'(gate), 32'h1D);
        rd_chk("resume", `CCRP_A_STATUS, 32'h60);
        run <= 1'b0;
        repeat (300) @(posedge pclk);
        check("sense2", 32'({sense_en, link_active}), 32'h0);
        report_and_stop();
    end
endmodule : test_ccrp_top
